// ==== verilog/uwe_top.sv ====
// Receiver wakeup, error detection and baud divider of an asynchronous serial port.
// Assumes an AHB-Lite master, a synchronous receive line and one-cycle source ticks.
//
// Summary of operation
// - Sleep bit blocks all receiver flags.
// - Software may clear sleep bit by write.
// - Idle line wakes receiver in idle mode.
// - Frame MSB one marks an address frame.
// - Address frame clears sleep before stop bit.
// - Full buffer: set overrun, drop new character.
// - Overrun clears on status then data read.
// - Noise flag rises only with receive full.
// - Noise clears on status then data read.
// - Missing stop sets framing with receive full.
// - Framing plus overrun reports only overrun.
// - Framing error blocks further data transfer.
// - Framing clears on status then data read.
// - Parity error set; status-data read clears.
// - Eight-bit traffic needs only low data register.
// - Baud is source over sixteen times divider.
// - Divider zero stops baud generator.
// - High divider five bits, bit5 zero, resets.
// - Test and split bits act in test mode.
// - Source clock is PLL or crystal tick.
// - Frame length bit picks nine or eight bits.
// - Receive full set, cleared by status-data read.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module uwe_top import uwe_pkg::*; (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Baud source ticks and selection.
   input wire logic pllTick,
   input wire logic xtalTick,
   input wire logic clockSourceSelect,
   input wire logic testMode,
   // Serial line and joins to the rest of the port.
   input wire logic rxd,
   output logic receiveFull,
   output logic lineIdle,
   output logic receiveEnable
);
   typedef struct packed {
      logic [7:0] bdh;
      logic [7:0] bdl;
      logic [4:0] cr1;
      logic re;
      logic receiver_sleep_bit;
      logic receive_full_flag, idle, ovr, nf, fe, pf;
      logic [5:0] armed;
      logic [8:0] rxData;
      logic [12:0] divCnt;
      logic tick;
      uwe_rx_e st;
      logic [3:0] smp;
      logic [3:0] bitIdx;
      logic [8:0] shift;
      logic par;
      logic noise;
      logic [1:0] votes;
      logic [7:0] idleCnt;
      logic wrPend;
      logic [9:0] wrIdx;
      logic [31:0] rdata;
   } uwe_state_s;

   uwe_state_s s_q, s_d;
   logic addrPhase;
   logic [9:0] idx;
   logic srcTick;
   logic [12:0] divVal;
   logic bitVal;
   logic lastBit;
   logic [7:0] idleLimit;
   logic [5:0] flagsNow;
   logic [3:0] nBits;
   // Flags set by hardware this cycle; a clear in the same cycle must not drop them.
   logic [5:0] setEv;

   assign addrPhase = hsel & htrans[1] & hready;
   assign idx = haddr[11:2];
   assign flagsNow = {s_q.receive_full_flag, s_q.idle, s_q.ovr, s_q.nf, s_q.fe, s_q.pf};
   assign nBits = s_q.cr1[CR1_M] ? 4'h9 : 4'h8;
   assign lastBit = (s_q.bitIdx == nBits - 4'h1);
   assign idleLimit = s_q.cr1[CR1_M] ? IDLE_TICKS_9 : IDLE_TICKS_8;

   // Test bits only bend the divider when the chip is in test mode.
   always_comb begin
      srcTick = clockSourceSelect ? xtalTick : pllTick;
      divVal = {s_q.bdh[4:0], s_q.bdl};
      if (testMode && s_q.bdh[BDH_TST] && divVal != 13'h0000) begin
         divVal = 13'h0001;
      end else if (testMode && s_q.bdh[BDH_SPL]) begin
         divVal = {5'h00, s_q.bdl};
      end
      // Three-sample majority; the third sample is the live line.
      bitVal = (s_q.votes[0] & s_q.votes[1]) | (s_q.votes[0] & rxd) | (s_q.votes[1] & rxd);
   end

   // Next-state logic for the bus slave, divider, receiver and flags.
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      setEv = 6'h00;
      // Divider: one sample tick per divider-many source ticks, sixteen per bit.
      if (divVal == 13'h0000) begin
         s_d.divCnt = 13'h0000;
      end else if (srcTick) begin
         if (s_q.divCnt + 13'h0001 >= divVal) begin
            s_d.divCnt = 13'h0000;
            s_d.tick = 1'b1;
         end else begin
            s_d.divCnt = s_q.divCnt + 13'h0001;
         end
      end
      // Receiver runs on sample ticks.
      if (!s_q.re) begin
         s_d.st = RX_IDLE;
         s_d.idleCnt = 8'h00;
      end else if (s_q.tick) begin
         // Idle counting; long type counts only once the frame has ended.
         if (rxd && (!s_q.cr1[CR1_ILT] || s_q.st == RX_IDLE)) begin
            if (s_q.idleCnt != idleLimit) begin
               s_d.idleCnt = s_q.idleCnt + 8'h01;
            end
            if (s_q.idleCnt + 8'h01 == idleLimit) begin
               if (!s_q.receiver_sleep_bit) begin
                  s_d.idle = 1'b1;
                  setEv[4] = 1'b1;
               end
               if (!s_q.cr1[CR1_WAKE]) begin
                  s_d.receiver_sleep_bit = 1'b0;
               end
            end
         end else begin
            s_d.idleCnt = 8'h00;
         end
         s_d.smp = s_q.smp + 4'h1;
         if (s_q.smp == SMP_A) begin
            s_d.votes[0] = rxd;
         end
         if (s_q.smp == SMP_B) begin
            s_d.votes[1] = rxd;
         end
         case (s_q.st)
            RX_IDLE: begin
               if (!rxd) begin
                  s_d.st = RX_START;
                  s_d.smp = 4'h1;
                  s_d.noise = 1'b0;
                  s_d.par = 1'b0;
                  s_d.bitIdx = 4'h0;
               end
            end
            RX_START: begin
               if (s_q.smp == SMP_C) begin
                  s_d.noise = s_q.votes != {rxd, rxd};
                  if (bitVal) begin
                     s_d.st = RX_IDLE; // A glitch, not a start bit.
                  end
               end else if (s_q.smp == SMP_END) begin
                  s_d.st = RX_DATA;
               end
            end
            RX_DATA: begin
               if (s_q.smp == SMP_C) begin
                  s_d.noise = s_q.noise | (s_q.votes != {rxd, rxd});
                  s_d.shift = {bitVal, s_q.shift[8:1]};
                  s_d.par = s_q.par ^ bitVal;
                  s_d.bitIdx = s_q.bitIdx + 4'h1;
                  // An address mark wakes the receiver ahead of the stop bit.
                  if (lastBit && bitVal && s_q.cr1[CR1_WAKE]) begin
                     s_d.receiver_sleep_bit = 1'b0;
                  end
               end else if (s_q.smp == SMP_END && s_q.bitIdx == nBits) begin
                  s_d.st = RX_STOP;
               end
            end
            RX_STOP: begin
               if (s_q.smp == SMP_C) begin
                  s_d.st = RX_IDLE;
                  if (!s_q.receiver_sleep_bit) begin
                     if (s_q.receive_full_flag || s_q.fe) begin
                        // Buffered character kept; framing not reported.
                        s_d.ovr = 1'b1;
                        setEv[3] = 1'b1;
                     end else begin
                        s_d.rxData = s_q.cr1[CR1_M] ? s_q.shift : {1'b0, s_q.shift[8:1]};
                        s_d.receive_full_flag = 1'b1;
                        s_d.nf = s_q.noise | (s_q.votes != {rxd, rxd});
                        s_d.fe = !bitVal;
                        s_d.pf = s_q.cr1[CR1_PE] & (s_q.par ^ s_q.cr1[CR1_PT]);
                        setEv[5] = 1'b1;
                        setEv[2:0] = {s_d.nf, s_d.fe, s_d.pf};
                     end
                  end
               end
            end
            default: s_d.st = RX_IDLE;
         endcase
      end
      // Bus write data phase.
      s_d.wrPend = 1'b0;
      if (s_q.wrPend) begin
         case (s_q.wrIdx)
            IDX_BDH: s_d.bdh = {hwdata[7:6], 1'b0, hwdata[4:0]};
            IDX_BDL: s_d.bdl = hwdata[7:0];
            IDX_CR1: s_d.cr1 = hwdata[4:0];
            IDX_CR2: begin
               s_d.re = hwdata[CR2_RE];
               s_d.receiver_sleep_bit = hwdata[CR2_RWU];
            end
            default: s_d.cr1 = s_d.cr1; // Unmapped or read-only words ignore writes.
         endcase
      end
      // Bus address phase: reads return data next cycle and act on the flags now.
      s_d.rdata = 32'h0000_0000;
      if (addrPhase) begin
         s_d.wrPend = hwrite;
         s_d.wrIdx = idx;
         if (!hwrite) begin
            case (idx)
               // Control words return their next value, so a read right after a write sees it.
               IDX_BDH: s_d.rdata = {24'h00_0000, s_d.bdh};
               IDX_BDL: s_d.rdata = {24'h00_0000, s_d.bdl};
               IDX_CR1: s_d.rdata = {27'h000_0000, s_d.cr1};
               IDX_CR2: s_d.rdata = {29'h0000_0000, s_d.re, s_d.receiver_sleep_bit, 1'b0};
               IDX_SR1: begin
                  s_d.rdata = {26'h000_0000, flagsNow};
                  s_d.armed = flagsNow;
               end
               IDX_SR2: s_d.rdata = {31'h0000_0000, s_q.st != RX_IDLE};
               IDX_DRH: s_d.rdata = {24'h00_0000, s_q.rxData[8], 7'h00};
               IDX_DRL: begin
                  s_d.rdata = {24'h00_0000, s_q.rxData[7:0]};
                  // Clear only flags seen by a prior status read; a new set still wins.
                  {s_d.receive_full_flag, s_d.idle, s_d.ovr, s_d.nf, s_d.fe, s_d.pf} =
                     ({s_d.receive_full_flag, s_d.idle, s_d.ovr, s_d.nf, s_d.fe, s_d.pf} &
                     ~(s_q.armed & flagsNow)) | setEv;
                  s_d.armed = 6'h00;
               end
               default: s_d.rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // All state in one register.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.bdh <= RST_BDH;
         s_q.bdl <= RST_BDL;
         s_q.st <= RX_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // Read data and flag outputs come straight from the state register; zero wait states, always OKAY.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign receiveFull = s_q.receive_full_flag;
   assign lineIdle = s_q.idle;
   assign receiveEnable = s_q.re;

   // Checks.
   property p_sleep_blocks;
      @(posedge clk_sys) disable iff (!nrst) s_q.receiver_sleep_bit && !s_q.wrPend |=> !$rose(s_q.receive_full_flag);
   endproperty
   a_sleep_blocks: assert property (p_sleep_blocks) else $error("flag set while asleep");
   property p_overrun_keeps;
      @(posedge clk_sys) disable iff (!nrst) $rose(s_q.ovr) |-> s_q.receive_full_flag && $stable(s_q.rxData);
   endproperty
   a_overrun_keeps: assert property (p_overrun_keeps) else $error("overrun lost data");
   property p_noise_with_full;
      @(posedge clk_sys) disable iff (!nrst) $rose(s_q.nf) |-> $rose(s_q.receive_full_flag);
   endproperty
   a_noise_with_full: assert property (p_noise_with_full) else $error("early noise");
   property p_frame_with_full;
      @(posedge clk_sys) disable iff (!nrst) $rose(s_q.fe) |-> $rose(s_q.receive_full_flag) && !$rose(s_q.ovr);
   endproperty
   a_frame_with_full: assert property (p_frame_with_full) else $error("framing timing");
   property p_fe_blocks;
      @(posedge clk_sys) disable iff (!nrst) s_q.fe ##1 s_q.fe |-> $stable(s_q.rxData);
   endproperty
   a_fe_blocks: assert property (p_fe_blocks) else $error("data moved under framing");
   property p_div_zero;
      @(posedge clk_sys) disable iff (!nrst)
         s_q.bdl == 8'h00 && s_q.bdh[4:0] == 5'h00 && !s_q.wrPend |=> !s_q.tick;
   endproperty
   a_div_zero: assert property (p_div_zero) else $error("divider zero ticked");
   property p_bit5_zero;
      @(posedge clk_sys) disable iff (!nrst) !s_q.bdh[5];
   endproperty
   a_bit5_zero: assert property (p_bit5_zero) else $error("high divider bit5 set");
   property p_no_arm_no_clear;
      @(posedge clk_sys) disable iff (!nrst)
         addrPhase && !hwrite && idx == IDX_DRL && s_q.armed == 6'h00 && s_q.receive_full_flag |=> s_q.receive_full_flag;
   endproperty
   a_no_arm_no_clear: assert property (p_no_arm_no_clear) else $error("flag cleared early");
   property p_clear_seq;
      @(posedge clk_sys) disable iff (!nrst)
         addrPhase && !hwrite && idx == IDX_DRL && s_q.armed[3] && s_q.ovr && !setEv[3]
         |=> !s_q.ovr;
   endproperty
   a_clear_seq: assert property (p_clear_seq) else $error("overrun not cleared");
   // Wakeup paths, delivery point and error priority.
   property p_sleep_no_idle;
      @(posedge clk_sys) disable iff (!nrst) s_q.receiver_sleep_bit |=> !$rose(s_q.idle) && !$rose(s_q.ovr);
   endproperty
   a_sleep_no_idle: assert property (p_sleep_no_idle) else $error("sleep flag set");
   property p_idle_wake;
      @(posedge clk_sys) disable iff (!nrst)
         $rose(s_q.idleCnt == idleLimit) && !$past(s_q.cr1[CR1_WAKE]) && !$past(s_q.wrPend)
         |-> !s_q.receiver_sleep_bit;
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle did not wake");
   property p_addr_wake;
      @(posedge clk_sys) disable iff (!nrst)
         $fell(s_q.receiver_sleep_bit) && $past(s_q.cr1[CR1_WAKE]) && !$past(s_q.wrPend) |-> s_q.st == RX_DATA;
   endproperty
   a_addr_wake: assert property (p_addr_wake) else $error("address wake too late");
   property p_full_at_stop;
      @(posedge clk_sys) disable iff (!nrst) $rose(s_q.receive_full_flag) |-> $past(s_q.st) == RX_STOP;
   endproperty
   a_full_at_stop: assert property (p_full_at_stop) else $error("full outside stop");
   property p_overrun_only;
      @(posedge clk_sys) disable iff (!nrst) $rose(s_q.ovr) |-> !$rose(s_q.fe);
   endproperty
   a_overrun_only: assert property (p_overrun_only) else $error("framing with overrun");
endmodule // uwe_top

// ==== verilog/uwe_pkg.sv ====
// Constants shared by the serial receiver wakeup, error and baud divider block.
// Assumes an AHB-Lite bus with 32-bit data; each register sits in the low bits of one word.
package uwe_pkg;
   // Register indices; the byte address on the bus is four times the index.
   localparam logic [9:0] IDX_BDH = 10'h070;
   localparam logic [9:0] IDX_BDL = 10'h071;
   localparam logic [9:0] IDX_CR1 = 10'h072;
   localparam logic [9:0] IDX_CR2 = 10'h073;
   localparam logic [9:0] IDX_SR1 = 10'h074;
   localparam logic [9:0] IDX_SR2 = 10'h075;
   localparam logic [9:0] IDX_DRH = 10'h076;
   localparam logic [9:0] IDX_DRL = 10'h077;
   // Reset values.
   localparam logic [7:0] RST_BDH = 8'h00;
   localparam logic [7:0] RST_BDL = 8'h04;
   // Field positions in the control registers.
   localparam int CR1_M = 4;
   localparam int CR1_WAKE = 3;
   localparam int CR1_ILT = 2;
   localparam int CR1_PE = 1;
   localparam int CR1_PT = 0;
   localparam int CR2_RE = 2;
   localparam int CR2_RWU = 1;
   localparam int BDH_TST = 7;
   localparam int BDH_SPL = 6;
   // Sample points within the sixteen ticks of one bit.
   localparam logic [3:0] SMP_A = 4'h7;
   localparam logic [3:0] SMP_B = 4'h8;
   localparam logic [3:0] SMP_C = 4'h9;
   localparam logic [3:0] SMP_END = 4'hf;
   // Idle line lengths in sample ticks: one whole frame of ones.
   localparam logic [7:0] IDLE_TICKS_8 = 8'ha0;
   localparam logic [7:0] IDLE_TICKS_9 = 8'hb0;
   // Receiver states.
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } uwe_rx_e;
endpackage

// ==== bench/uwe_node_model.sv ====
// Behavioural serial node that sends frames onto the shared receive line.
// Assumes one caller at a time; the line rests high like a pulled-up wire.
`timescale 1ns/1ps
module uwe_node_model (
   // Clock and line.
   input wire logic clk_sys,
   output logic rxd
);
   initial rxd = 1'b1;
   // Start bit, data LSB first, then the stop level. A bad stop is cut short so that
   // the line returns high before a false start seen after the stop sample is checked. No gap is added, so
   // frames sent back to back form one message.
   task automatic send_frame(input int bitLen, input int nBits, input logic [8:0] data,
         input logic stopLvl, input int noiseBit);
      logic lvl;
      for (int i = 0; i <= nBits + 1; i++) begin
         for (int j = 0; j < bitLen; j++) begin
            lvl = (i == 0) ? 1'b0 : (i <= nBits) ? data[i - 1] : stopLvl;
            if (i > nBits && j >= bitLen * 13 / 16) begin
               lvl = 1'b1;
            end
            @(posedge clk_sys);
            // A negative noise index leaves the frame clean, start bit included.
            rxd <= (noiseBit >= 0 && i == noiseBit + 1 && j == bitLen / 2) ? ~lvl : lvl;
         end
      end
   endtask
   // Holds the line idle; callers leave a whole frame time between messages.
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         rxd <= 1'b1;
      end
   endtask
endmodule // uwe_node_model

// ==== bench/uwe_top_tb.sv ====
// Self-checking bench for the receiver wakeup, error and baud divider block.
// Assumes source ticks held high (one tick a cycle), so divider 1 gives 16 cycles a bit.
`timescale 1ns/1ps
module uwe_top_tb import uwe_pkg::*; ();
   logic clk_sys, nrst, hsel, hwrite, pllTick, xtalTick, clockSourceSelect, testMode;
   logic [31:0] haddr, hwdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire logic hready, hreadyout, hresp, rxd, receiveFull, lineIdle, receiveEnable;
   wire logic [31:0] hrdata;
   int fail_count = 0;
   int tests_run = 0;
   // The single slave's ready is the bus ready.
   assign hready = hreadyout;
   uwe_top uwe_top_inst (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pllTick(pllTick),
      .xtalTick(xtalTick), .clockSourceSelect(clockSourceSelect), .testMode(testMode),
      .rxd(rxd), .receiveFull(receiveFull), .lineIdle(lineIdle),
      .receiveEnable(receiveEnable));
   uwe_node_model uwe_node_model_inst (.clk_sys(clk_sys), .rxd(rxd));
   // Prints the verdict and ends the run.
   task automatic report_and_stop();
      if (fail_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // One single transfer; values are read just before the edge that samples them,
   // which avoids a race with the registered read data.
   task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] wd,
         output logic [31:0] rd);
      logic rdy;
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {20'h0, idx, 2'b00};
      do begin
         @(negedge clk_sys);
         rdy = hready;
         @(posedge clk_sys);
      end while (rdy !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do begin
         @(negedge clk_sys);
         rdy = hready;
         rd = hrdata;
         @(posedge clk_sys);
      end while (rdy !== 1'b1);
      chk({31'h0, hresp}, 32'h0, "response");
   endtask
   task automatic wr(input logic [9:0] idx, input logic [31:0] v);
      logic [31:0] d;
      bus(1'b1, idx, v, d);
   endtask
   task automatic rc(input logic [9:0] idx, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] d;
      bus(1'b0, idx, 32'h0, d);
      chk(d & m, e, $sformatf("register %h", idx));
   endtask
   task automatic fl(input logic e);
      chk({31'h0, receiveFull}, {31'h0, e}, "receive full");
   endtask
   task automatic fr(input int bl, input int nb, input logic [8:0] d, input logic s, input int n);
      uwe_node_model_inst.send_frame(bl, nb, d, s, n);
      repeat (4) @(posedge clk_sys);
   endtask
   // Status read, then data read: the normal way to take a clean character.
   task automatic cl(input logic [31:0] d);
      rc(IDX_SR1, 32'h20, 32'h2f);
      rc(IDX_DRL, d, 32'hff);
   endtask
   // Scenarios.
   task automatic t_regs();
      rc(IDX_BDH, {24'h0, RST_BDH}, 32'hffffffff);
      rc(IDX_BDL, {24'h0, RST_BDL}, 32'hffffffff);
      wr(IDX_BDH, 32'hff);
      rc(IDX_BDH, 32'hdf, 32'hffffffff);
      wr(10'h07f, 32'hff);
      rc(10'h07f, 32'h0, 32'hffffffff);
      wr(IDX_BDH, 32'h0);
      wr(IDX_BDL, 32'h1);
      wr(IDX_CR2, 32'h1 << CR2_RE);
      rc(IDX_CR2, 32'h4, 32'hffffffff);
      chk({31'h0, receiveEnable}, 32'h1, "receive enable");
   endtask
   task automatic t_basic();
      fr(16, 8, 9'h0a5, 1'b1, -1);
      fl(1'b1);
      cl(32'ha5);
      fl(1'b0);
      uwe_node_model_inst.idle(170);
      chk({31'h0, lineIdle}, 32'h1, "idle line");
      rc(IDX_SR1, 32'h10, 32'h10);
      rc(IDX_DRL, 32'ha5, 32'hff);
      chk({31'h0, lineIdle}, 32'h0, "idle cleared");
   endtask
   task automatic t_overrun();
      fr(16, 8, 9'h011, 1'b1, -1);
      fr(16, 8, 9'h022, 1'b0, -1);
      rc(IDX_SR1, 32'h28, 32'h2f);
      rc(IDX_DRL, 32'h11, 32'hff);
      rc(IDX_SR1, 32'h0, 32'h2f);
   endtask
   task automatic t_framing();
      fr(16, 8, 9'h033, 1'b0, -1);
      fl(1'b1);
      rc(IDX_DRL, 32'h33, 32'hff);
      fl(1'b1);
      fr(16, 8, 9'h044, 1'b1, -1);
      rc(IDX_SR1, 32'h2a, 32'h2f);
      rc(IDX_DRL, 32'h33, 32'hff);
      rc(IDX_SR1, 32'h0, 32'h2f);
   endtask
   task automatic t_noise();
      fr(16, 8, 9'h05a, 1'b1, 3);
      rc(IDX_SR1, 32'h24, 32'h2f);
      rc(IDX_DRL, 32'h5a, 32'hff);
      rc(IDX_SR1, 32'h0, 32'h2f);
   endtask
   task automatic t_parity();
      wr(IDX_CR1, 32'h1 << CR1_PE);
      fr(16, 8, 9'h0d5, 1'b1, -1);
      rc(IDX_SR1, 32'h21, 32'h2f);
      rc(IDX_DRL, 32'h55, 32'h7f);
      rc(IDX_SR1, 32'h0, 32'h2f);
      fr(16, 8, 9'h055, 1'b1, -1);
      cl(32'h55);
      wr(IDX_CR1, 32'h3);
      fr(16, 8, 9'h0d5, 1'b1, -1);
      cl(32'hd5);
      wr(IDX_CR1, 32'h0);
   endtask
   task automatic t_nine();
      wr(IDX_CR1, 32'h1 << CR1_M);
      fr(16, 9, 9'h1c3, 1'b1, -1);
      rc(IDX_SR1, 32'h20, 32'h2f);
      // Software writes the high data word first; the receive buffer must not move.
      wr(IDX_DRH, 32'h0);
      wr(IDX_DRL, 32'h0);
      rc(IDX_DRH, 32'h80, 32'h80);
      rc(IDX_DRL, 32'hc3, 32'hff);
      fl(1'b0);
      wr(IDX_CR1, 32'h0);
   endtask
   // Receiver enable and sleep set together.
   task automatic t_addr();
      wr(IDX_CR1, 32'h1 << CR1_WAKE);
      wr(IDX_CR2, 32'h6);
      fr(16, 8, 9'h012, 1'b1, -1);
      fl(1'b0);
      rc(IDX_SR1, 32'h0, 32'h2f);
      fr(16, 8, 9'h092, 1'b1, -1);
      rc(IDX_CR2, 32'h4, 32'hff);
      cl(32'h92);
      wr(IDX_CR1, 32'h0);
   endtask
   task automatic t_idle();
      logic [31:0] d;
      wr(IDX_CR2, 32'h6);
      rc(IDX_CR2, 32'h6, 32'hff);
      wr(IDX_CR2, 32'h4);
      rc(IDX_CR2, 32'h4, 32'hff);
      wr(IDX_CR2, 32'h6);
      fr(16, 8, 9'h012, 1'b1, -1);
      uwe_node_model_inst.idle(200);
      rc(IDX_CR2, 32'h4, 32'hff);
      chk({31'h0, lineIdle}, 32'h0, "idle while asleep");
      bus(1'b0, IDX_SR1, 32'h0, d);
      bus(1'b0, IDX_DRL, 32'h0, d);
   endtask
   task automatic t_baud();
      wr(IDX_BDL, 32'h2);
      fr(32, 8, 9'h03c, 1'b1, -1);
      cl(32'h3c);
      testMode <= 1'b1;
      wr(IDX_BDL, 32'h3);
      wr(IDX_BDH, 32'h1 << BDH_TST);
      fr(16, 8, 9'h069, 1'b1, -1);
      cl(32'h69);
      testMode <= 1'b0;
      wr(IDX_BDH, 32'h0);
      wr(IDX_BDL, 32'h1);
      pllTick <= 1'b0;
      clockSourceSelect <= 1'b1;
      fr(16, 8, 9'h04b, 1'b1, -1);
      cl(32'h4b);
   endtask
   task automatic t_stop();
      wr(IDX_BDL, 32'h0);
      fr(16, 8, 9'h077, 1'b1, -1);
      fl(1'b0);
      rc(IDX_SR1, 32'h0, 32'h2f);
   endtask
   // Free-running system clock.
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Main sequence.
   initial begin
      nrst = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      pllTick = 1'b1;
      xtalTick = 1'b1;
      clockSourceSelect = 1'b0;
      testMode = 1'b0;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      t_regs();
      t_basic();
      t_overrun();
      t_framing();
      t_noise();
      t_parity();
      t_nine();
      t_addr();
      t_idle();
      t_baud();
      t_stop();
      report_and_stop();
   end
   // The whole run needs well under a third of this span.
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      report_and_stop();
   end
endmodule // uwe_top_tb
